// file: common/pfrec_pkg.sv
package pfrec_pkg;
  // register byte addresses on the plain register port (word index = byte address / 4)
  localparam logic [7:0] ADDR_CAP         = 8'h00;
  localparam logic [7:0] ADDR_GSTS        = 8'h04;
  localparam logic [7:0] ADDR_FSTS        = 8'h08;
  localparam logic [7:0] ADDR_FECTL       = 8'h0C;
  localparam logic [7:0] ADDR_RTCFG       = 8'h10;
  localparam logic [7:0] ADDR_FRR_BASE    = 8'h40;
  // each recording register takes four words: source, reason, addr lo, addr hi/valid
  localparam int         FRR_WORDS        = 4;
  // fault status bits
  localparam int         FSTS_PFO_BIT     = 0;
  localparam int         FSTS_PPF_BIT     = 1;
  localparam int         FSTS_IQE_BIT     = 4;
  localparam int         FSTS_ICE_BIT     = 5;
  localparam int         FSTS_ITE_BIT     = 6;
  localparam int         FSTS_FRI_LSB     = 8;
  // fault event control bits
  localparam int         FECTL_IP_BIT     = 30;
  localparam int         FECTL_IM_BIT     = 31;
  // global status bits
  localparam int         GSTS_TES_BIT     = 31;
  localparam int         GSTS_IES_BIT     = 25;
  // capability fields
  localparam int         CAP_ZLR_BIT      = 22;
  localparam int         CAP_NFR_LSB      = 40 - 32;
  localparam int         CAP_CMP_BIT     = 16;
  // configuration bits
  localparam int         RTCFG_MODE_LSB   = 10;
  // table mode encodings
  localparam logic [1:0] MODE_SCALABLE    = 2'h1;
  // fault reasons
  localparam logic [7:0] FR_HPT_WRITE     = 8'hA4;
  localparam logic [7:0] FR_HPT_READ      = 8'hA5;
  // request kinds
  typedef enum logic [2:0] {
    REQ_UNTRANSLATED = 3'h0,
    REQ_TRANSLATION  = 3'h1,
    REQ_TRANSLATED   = 3'h2,
    REQ_PAGE_RESP    = 3'h3,
    REQ_PAGE_NORESP  = 3'h4
  } pfrec_req_type;
  // completion kinds
  typedef enum logic [1:0] {
    CPL_SUCCESS      = 2'h0,
    CPL_UR           = 2'h1,
    CPL_IR           = 2'h2,
    CPL_NONE         = 2'h3
  } pfrec_cpl_type;
  // reset values
  localparam logic [1:0] RST_MODE         = 2'h0;
endpackage

// file: src/pfrec_top.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module pfrec_top #(
  parameter int NUM_REC   = 8,
  parameter bit COMPRESS  = 1'b1,
  parameter bit ZLR_SUPP  = 1'b1,
  parameter int AW        = 64
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic [31:0]         i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [31:0]         o_reg_rdata,
  input  wire logic                i_req_valid,
  input  wire pfrec_pkg::pfrec_req_type i_req_kind,
  input  wire logic [15:0]         i_req_source,
  input  wire logic [AW-1:0]       i_req_addr,
  input  wire logic                i_req_write,
  input  wire logic                i_req_read,
  input  wire logic                i_req_zero_len,
  input  wire logic                i_ctx_hpt_en,
  input  wire logic                i_hpt_wr_ok,
  input  wire logic                i_hpt_rd_ok,
  input  wire logic                i_pt_blocked,
  input  wire logic                i_other_fault,
  input  wire logic [7:0]          i_other_reason,
  input  wire logic                i_inv_err_set,
  input  wire logic [2:0]          i_inv_err_bits,
  output logic                     o_cpl_valid,
  output pfrec_pkg::pfrec_cpl_type o_cpl_kind,
  output logic                     o_prq_write,
  output logic                     o_event_msg
);
  localparam int IW = (NUM_REC > 1) ? $clog2(NUM_REC) : 1;

  logic [1:0]    table_mode_r;
  logic          tes_r;
  logic          ies_r;
  logic          pfo_r;
  logic [2:0]    inv_err_r;
  logic [IW-1:0] fri_r;
  logic [IW-1:0] idx_r;
  logic [IW-1:0] idx_nxt;
  logic          im_r;
  logic          ip_r;
  logic          primary_pending_fault;
  logic [NUM_REC-1:0]  rec_valid_r;
  logic [15:0]   rec_src_r    [NUM_REC];
  logic [7:0]    rec_reason_r [NUM_REC];
  logic [AW-1:0] rec_addr_r   [NUM_REC];
  logic [NUM_REC-1:0]  src_match;
  logic [NUM_REC-1:0]  sw_clr_valid;

  // fault classification
  logic          scal_hpt;
  logic          hpt_wr_flt;
  logic          hpt_rd_flt;
  logic          xlat_blk;
  logic          page_flt;
  logic          fault_in;
  logic [7:0]    fault_reason;
  logic          do_record;
  logic          do_ovf;
  logic          evt_cond;
  logic          sw_pfo_clr;
  logic          busy_status;

  always_comb begin
    scal_hpt   = i_req_valid && (i_req_kind == pfrec_pkg::REQ_TRANSLATED) &&
                 (table_mode_r == pfrec_pkg::MODE_SCALABLE) && i_ctx_hpt_en;
    hpt_wr_flt = scal_hpt && i_req_write && !i_hpt_wr_ok;
    hpt_rd_flt = scal_hpt && i_req_read && !i_hpt_rd_ok &&
                 !(ZLR_SUPP && i_req_zero_len);
    xlat_blk   = i_req_valid && (i_req_kind == pfrec_pkg::REQ_TRANSLATION) && i_pt_blocked;
    page_flt   = i_req_valid && i_other_fault &&
                 ((i_req_kind == pfrec_pkg::REQ_PAGE_RESP) || (i_req_kind == pfrec_pkg::REQ_PAGE_NORESP));
    fault_in   = hpt_wr_flt || hpt_rd_flt || (i_req_valid && i_other_fault);
    if (hpt_wr_flt) begin
      fault_reason = pfrec_pkg::FR_HPT_WRITE;
    end else if (hpt_rd_flt) begin
      fault_reason = pfrec_pkg::FR_HPT_READ;
    end else begin
      fault_reason = i_other_reason;
    end
  end

  // completion response
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cpl_valid <= 1'b0;
      o_cpl_kind  <= pfrec_pkg::CPL_SUCCESS;
      o_prq_write <= 1'b0;
    end else if (i_ce) begin
      o_cpl_valid <= i_req_valid && (i_req_kind != pfrec_pkg::REQ_PAGE_NORESP || !page_flt);
      o_prq_write <= i_req_valid && !page_flt &&
                     ((i_req_kind == pfrec_pkg::REQ_PAGE_RESP) || (i_req_kind == pfrec_pkg::REQ_PAGE_NORESP));
      if (hpt_wr_flt || hpt_rd_flt || xlat_blk) begin
        o_cpl_kind <= pfrec_pkg::CPL_UR;
      end else if (page_flt) begin
        o_cpl_kind <= (i_req_kind == pfrec_pkg::REQ_PAGE_RESP) ? pfrec_pkg::CPL_IR
                                                               : pfrec_pkg::CPL_NONE;
      end else if (i_req_valid && i_other_fault) begin
        o_cpl_kind <= pfrec_pkg::CPL_UR;
      end else begin
        o_cpl_kind <= pfrec_pkg::CPL_SUCCESS;
      end
    end
  end

  // recording decision
  always_comb begin
    primary_pending_fault = |rec_valid_r;
    for (int k = 0; k < NUM_REC; k++) begin
      src_match[k] = COMPRESS && rec_valid_r[k] && (rec_src_r[k] == i_req_source);
      sw_clr_valid[k] = i_reg_wr && (i_reg_addr == 8'(pfrec_pkg::ADDR_FRR_BASE + k * pfrec_pkg::FRR_WORDS * 4 + 12))
                        && i_reg_wdata[31];
    end
    do_ovf    = fault_in && !pfo_r && !(|src_match) && rec_valid_r[idx_r];
    do_record = fault_in && !pfo_r && !(|src_match) && !rec_valid_r[idx_r];
    idx_nxt   = (idx_r == IW'(NUM_REC - 1)) ? '0 : idx_r + 1'b1;
    sw_pfo_clr = i_reg_wr && (i_reg_addr == pfrec_pkg::ADDR_FSTS) && i_reg_wdata[pfrec_pkg::FSTS_PFO_BIT];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_r <= '0;
    end else if (i_ce) begin
      if (!tes_r && !ies_r) begin
        idx_r <= '0;
      end else if (do_record) begin
        idx_r <= idx_nxt;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fri_r <= '0;
    end else if (i_ce && do_record && !primary_pending_fault) begin
      fri_r <= idx_r;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pfo_r <= 1'b0;
    end else if (i_ce) begin
      if (do_ovf) begin
        pfo_r <= 1'b1;
      end else if (sw_pfo_clr) begin
        pfo_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      inv_err_r <= '0;
    end else if (i_ce) begin
      for (int b = 0; b < 3; b++) begin
        if (i_inv_err_set && i_inv_err_bits[b]) begin
          inv_err_r[b] <= 1'b1;
        end else if (i_reg_wr && (i_reg_addr == pfrec_pkg::ADDR_FSTS) &&
                     i_reg_wdata[pfrec_pkg::FSTS_IQE_BIT + b]) begin
          inv_err_r[b] <= 1'b0;
        end
      end
    end
  end

  // recording registers
  for (genvar g = 0; g < NUM_REC; g++) begin : g_rec
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        rec_valid_r[g]  <= 1'b0;
        rec_src_r[g]    <= '0;
        rec_reason_r[g] <= '0;
        rec_addr_r[g]   <= '0;
      end else if (i_ce) begin
        if (do_record && (idx_r == IW'(g))) begin
          rec_valid_r[g]  <= 1'b1;
          rec_src_r[g]    <= i_req_source;
          rec_reason_r[g] <= fault_reason;
          rec_addr_r[g]   <= i_req_addr;
        end else if (sw_clr_valid[g]) begin
          rec_valid_r[g]  <= 1'b0;
        end
      end
    end
  end

  // configuration and global status
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      table_mode_r <= pfrec_pkg::RST_MODE;
      tes_r        <= 1'b0;
      ies_r        <= 1'b0;
    end else if (i_ce) begin
      if (i_reg_wr && (i_reg_addr == pfrec_pkg::ADDR_RTCFG)) begin
        table_mode_r <= i_reg_wdata[pfrec_pkg::RTCFG_MODE_LSB +: 2];
      end
      if (i_reg_wr && (i_reg_addr == pfrec_pkg::ADDR_GSTS)) begin
        tes_r <= i_reg_wdata[pfrec_pkg::GSTS_TES_BIT];
        ies_r <= i_reg_wdata[pfrec_pkg::GSTS_IES_BIT];
      end
    end
  end

  // fault event generation
  always_comb begin
    busy_status = primary_pending_fault || pfo_r || (|inv_err_r);
    evt_cond    = (do_record && !primary_pending_fault && !pfo_r && !(|inv_err_r)) ||
                  (i_inv_err_set && (|i_inv_err_bits) && !busy_status);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      im_r        <= 1'b0;
      ip_r        <= 1'b0;
      o_event_msg <= 1'b0;
    end else if (i_ce) begin
      o_event_msg <= 1'b0;
      if (i_reg_wr && (i_reg_addr == pfrec_pkg::ADDR_FECTL)) begin
        im_r <= i_reg_wdata[pfrec_pkg::FECTL_IM_BIT];
      end
      if (evt_cond) begin
        if (!im_r) begin
          o_event_msg <= 1'b1;
          ip_r        <= 1'b0;
        end else begin
          ip_r        <= 1'b1;
        end
      end else if (ip_r && i_reg_wr && (i_reg_addr == pfrec_pkg::ADDR_FECTL) &&
                   !i_reg_wdata[pfrec_pkg::FECTL_IM_BIT]) begin
        o_event_msg <= 1'b1;
        ip_r        <= 1'b0;
      end else if (ip_r && !busy_status) begin
        ip_r <= 1'b0;
      end
    end
  end

  // register read
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else if (i_ce) begin
      o_reg_rdata <= '0;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          pfrec_pkg::ADDR_CAP: begin
            o_reg_rdata[pfrec_pkg::CAP_NFR_LSB +: 8] <= 8'(NUM_REC - 1);
            o_reg_rdata[pfrec_pkg::CAP_ZLR_BIT]      <= ZLR_SUPP;
            o_reg_rdata[pfrec_pkg::CAP_CMP_BIT]      <= COMPRESS;
          end
          pfrec_pkg::ADDR_GSTS: begin
            o_reg_rdata[pfrec_pkg::GSTS_TES_BIT] <= tes_r;
            o_reg_rdata[pfrec_pkg::GSTS_IES_BIT] <= ies_r;
          end
          pfrec_pkg::ADDR_FSTS: begin
            o_reg_rdata[pfrec_pkg::FSTS_PFO_BIT]      <= pfo_r;
            o_reg_rdata[pfrec_pkg::FSTS_PPF_BIT]      <= primary_pending_fault;
            o_reg_rdata[pfrec_pkg::FSTS_IQE_BIT +: 3] <= inv_err_r;
            o_reg_rdata[pfrec_pkg::FSTS_FRI_LSB +: IW] <= fri_r;
          end
          pfrec_pkg::ADDR_FECTL: begin
            o_reg_rdata[pfrec_pkg::FECTL_IM_BIT] <= im_r;
            o_reg_rdata[pfrec_pkg::FECTL_IP_BIT] <= ip_r;
          end
          pfrec_pkg::ADDR_RTCFG: begin
            o_reg_rdata[pfrec_pkg::RTCFG_MODE_LSB +: 2] <= table_mode_r;
          end
          default: begin
            for (int k = 0; k < NUM_REC; k++) begin
              if (i_reg_addr[7:4] == 4'(pfrec_pkg::ADDR_FRR_BASE[7:4] + k)) begin
                unique case (i_reg_addr[3:0])
                  4'h0: o_reg_rdata <= {16'h0000, rec_src_r[k]};
                  4'h4: o_reg_rdata <= {24'h000000, rec_reason_r[k]};
                  4'h8: o_reg_rdata <= rec_addr_r[k][31:0];
                  4'hC: o_reg_rdata <= {rec_valid_r[k], rec_addr_r[k][AW-2:32]};
                  default: o_reg_rdata <= '0;
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  // checks
  chk_hpt_write_ur: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && hpt_wr_flt) |=> (o_cpl_kind == pfrec_pkg::CPL_UR))
    else $error("host table write fault not answered with UR");
  chk_zlr_no_fault: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ZLR_SUPP && i_req_zero_len) |-> !hpt_rd_flt)
    else $error("zero length read raised read fault");
  chk_page_resp_ir: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && page_flt && i_req_kind == pfrec_pkg::REQ_PAGE_RESP && !hpt_wr_flt && !hpt_rd_flt)
    |=> (o_cpl_kind == pfrec_pkg::CPL_IR && o_cpl_valid))
    else $error("faulting page request not answered with IR");
  chk_index_cleared: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && !tes_r && !ies_r) |=> (idx_r == '0))
    else $error("index not cleared while translation disabled");
  chk_index_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && do_record && tes_r) |=> (idx_r == $past(idx_nxt)))
    else $error("index did not advance after record");
  chk_ovf_discard: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (pfo_r && fault_in) |-> !do_record)
    else $error("fault recorded during overflow");
  chk_full_sets_ovf: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && do_ovf) |=> (pfo_r && $stable(rec_valid_r)))
    else $error("full index did not raise overflow");
  chk_first_index: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && do_record && !primary_pending_fault) |=> (fri_r == $past(idx_r) && rec_valid_r[fri_r]))
    else $error("first record index not captured");
  chk_event_masked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && evt_cond && im_r) |=> (ip_r && !o_event_msg))
    else $error("masked event not held pending");
endmodule // pfrec_top

// file: test/pfrec_endpoint.sv
`timescale 1ns/10ps
module pfrec_endpoint #(
  parameter int AW = 64
) (
  input  wire logic                i_ref_clk,
  output logic                     o_valid,
  output pfrec_pkg::pfrec_req_type o_kind,
  output logic [15:0]              o_source,
  output logic [AW-1:0]            o_addr,
  output logic                     o_write,
  output logic                     o_read,
  output logic                     o_zero_len
);
  initial begin
    o_valid = 1'b0;
    o_kind = pfrec_pkg::REQ_UNTRANSLATED;
    o_source = 16'h0000;
    o_addr = '0;
    o_write = 1'b0;
    o_read = 1'b0;
    o_zero_len = 1'b0;
  end

  // one request per call; address field is derived from the source
  task automatic issue(input logic [2:0] kind, input logic [15:0] src, input logic wr, input logic rd,
                       input logic zl);
    @(posedge i_ref_clk);
    o_valid <= 1'b1;
    o_kind <= pfrec_pkg::pfrec_req_type'(kind);
    o_source <= src;
    o_addr <= AW'({src, 16'h1230});
    o_write <= wr;
    o_read <= rd;
    o_zero_len <= zl;
    @(posedge i_ref_clk);
    o_valid <= 1'b0;
    // idle source and address flip so stale values never look valid
    o_source <= ~o_source;
    o_addr <= ~o_addr;
  endtask
endmodule // pfrec_endpoint

// file: test/pfrec_top_tb_top.sv
`timescale 1ns/10ps
module pfrec_top_tb_top;
  typedef struct packed {
    logic [2:0] kind;
    logic       wr, rd, zl, host_permission_table, wok, rok, blk, oth, cv;
    logic [1:0] ck;
    logic       prq;
  } pfrec_row_type;
  localparam int NREC = 8;
  logic                     i_ref_clk = 1'b0;
  logic                     i_rst = 1'b1;
  logic [7:0]               reg_addr = 8'h00;
  logic [31:0]              reg_wdata = 32'h0;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic [31:0]              reg_rdata;
  logic                     hpt_en = 1'b0, wr_ok = 1'b1, rd_ok = 1'b1, blk = 1'b0, oth = 1'b0;
  logic                     inv_set = 1'b0;
  logic [2:0]               inv_bits = 3'h0;
  logic [7:0]               oth_reason = 8'h33;
  logic                     req_valid, req_write, req_read, req_zero_len;
  pfrec_pkg::pfrec_req_type req_kind;
  logic [15:0]              req_source;
  logic [63:0]              req_addr;
  logic                     cpl_valid, prq_write, event_msg;
  pfrec_pkg::pfrec_cpl_type cpl_kind;
  int                       bad_count = 0;
  int                       samples_checked = 0;
  pfrec_row_type rows [8] = '{
    '{3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0},
    '{3'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0},
    '{3'h2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0},
    '{3'h2, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0},
    '{3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0},
    '{3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0},
    '{3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0},
    '{3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0}
  };

  pfrec_top #(.NUM_REC(NREC), .COMPRESS(1'b1), .ZLR_SUPP(1'b1), .AW(64)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_req_valid(req_valid),
    .i_req_kind(req_kind), .i_req_source(req_source), .i_req_addr(req_addr), .i_req_write(req_write),
    .i_req_read(req_read), .i_req_zero_len(req_zero_len), .i_ctx_hpt_en(hpt_en), .i_hpt_wr_ok(wr_ok),
    .i_hpt_rd_ok(rd_ok), .i_pt_blocked(blk), .i_other_fault(oth), .i_other_reason(oth_reason),
    .i_inv_err_set(inv_set), .i_inv_err_bits(inv_bits), .o_cpl_valid(cpl_valid), .o_cpl_kind(cpl_kind),
    .o_prq_write(prq_write), .o_event_msg(event_msg));

  pfrec_endpoint ep_u (
    .i_ref_clk(i_ref_clk), .o_valid(req_valid), .o_kind(req_kind), .o_source(req_source),
    .o_addr(req_addr), .o_write(req_write), .o_read(req_read), .o_zero_len(req_zero_len));

  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    @(posedge i_ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata & m);
  endtask

  task automatic do_reset;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    wr(8'h10, 32'h0000_0400);
    wr(8'h04, 32'h8000_0000);
  endtask

  // translated write without write permission
  task automatic fault(input logic [15:0] src);
    ep_u.issue(3'h2, src, 1'b1, 1'b0, 1'b0);
    #1;
  endtask

  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    logic ev;
    do_reset();
    rchk(8'h00, 32'h0041_FF00, 32'h0041_0700, "cap");
    rchk(8'hFC, 32'hFFFF_FFFF, 32'h0, "unmapped");
    foreach (rows[i]) begin
      @(posedge i_ref_clk);
      hpt_en <= rows[i].host_permission_table;
      wr_ok <= rows[i].wok;
      rd_ok <= rows[i].rok;
      blk <= rows[i].blk;
      oth <= rows[i].oth;
      ep_u.issue(rows[i].kind, 16'h0100 + 16'(i), rows[i].wr, rows[i].rd, rows[i].zl);
      #1;
      chk("cpl_valid", {31'h0, rows[i].cv}, {31'h0, cpl_valid});
      if (rows[i].cv) chk("cpl_kind", {30'h0, rows[i].ck}, {30'h0, cpl_kind});
      chk("prq_write", {31'h0, rows[i].prq}, {31'h0, prq_write});
    end
    do_reset();
    @(posedge i_ref_clk);
    hpt_en <= 1'b1;
    wr_ok <= 1'b0;
    blk <= 1'b0;
    oth <= 1'b0;
    fault(16'h0011);
    chk("event_first", 32'h1, {31'h0, event_msg});
    rchk(8'h08, 32'h0000_0703, 32'h0000_0002, "fsts_first");
    rchk(8'h40, 32'h0000_FFFF, 32'h0000_0011, "rec0_src");
    rchk(8'h44, 32'h0000_00FF, 32'h0000_00A4, "rec0_reason");
    rchk(8'h48, 32'hFFFF_FFFF, 32'h0011_1230, "rec0_addr");
    rchk(8'h4C, 32'h8000_0000, 32'h8000_0000, "rec0_valid");
    fault(16'h0011);
    chk("event_again", 32'h0, {31'h0, event_msg});
    for (int k = 1; k < NREC; k++) fault(16'h0011 + 16'(k));
    rchk(8'h50, 32'h0000_FFFF, 32'h0000_0012, "rec1_src");
    rchk(8'hB0, 32'h0000_FFFF, 32'h0000_0018, "rec7_src");
    fault(16'h0020);
    rchk(8'h08, 32'h0000_0001, 32'h0000_0001, "pfo_set");
    rchk(8'h40, 32'h0000_FFFF, 32'h0000_0011, "rec0_kept");
    wr(8'h4C, 32'h8000_0000);
    fault(16'h0021);
    rchk(8'h4C, 32'h8000_0000, 32'h0, "pfo_discard");
    for (int k = 1; k < NREC; k++) wr(8'h4C + 8'(16 * k), 32'h8000_0000);
    rchk(8'h08, 32'h0000_0003, 32'h0000_0001, "ppf_clear");
    wr(8'h08, 32'h0000_0001);
    rchk(8'h08, 32'h0000_0001, 32'h0, "pfo_clear");
    @(posedge i_ref_clk);
    inv_set <= 1'b1;
    inv_bits <= 3'h7;
    @(posedge i_ref_clk);
    inv_set <= 1'b0;
    fault(16'h0022);
    chk("event_inv", 32'h0, {31'h0, event_msg});
    rchk(8'h40, 32'h0000_FFFF, 32'h0000_0022, "resume_src");
    rchk(8'h08, 32'h0000_0773, 32'h0000_0072, "fsts_resume");
    wr(8'h08, 32'h0000_0070);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h8000_0000);
    wr(8'h4C, 32'h8000_0000);
    wr(8'h0C, 32'h8000_0000);
    fault(16'h0023);
    chk("event_masked", 32'h0, {31'h0, event_msg});
    rchk(8'h40, 32'h0000_FFFF, 32'h0000_0023, "idx_zero_src");
    rchk(8'h0C, 32'h4000_0000, 32'h4000_0000, "ip_held");
    wr(8'h0C, 32'h0);
    ev = 1'b0;
    repeat (5) begin
      #1 ev = ev | event_msg;
      @(posedge i_ref_clk);
    end
    chk("event_unmask", 32'h1, {31'h0, ev});
    tally_and_finish();
  end
endmodule // pfrec_top_tb_top
